/* dv/dspc_fabric_model.sv */
// dspc_fabric_model: fabric logic pacing the block clocks and enables.
// assumes one request at a time, go a one-cycle strobe on clk.
`timescale 1ns/1ns
module dspc_fabric_model
  import dspc_pkg::*;
#(
  parameter int HALF_T = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [1:0] grp,
  input wire logic en,
  output logic [DSPC_GROUPS-1:0] blk_clk,
  output logic [DSPC_GROUPS-1:0] reg_en,
  output logic busy
);
  // ************
  // clock pacing
  // ************
  int cnt;
  // high and low phases stay above the three cycles the sampler needs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      blk_clk <= '0;
      reg_en <= '0;
      busy <= 1'b0;
    end else if (go) begin
      cnt <= 2 * HALF_T;
      blk_clk[grp] <= 1'b1;
      reg_en[grp] <= en;
      busy <= 1'b1;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == HALF_T)
        blk_clk <= '0;
      if (cnt == 1)
        busy <= 1'b0;
      if (cnt == 1)
        reg_en <= '0;
    end
  end
endmodule

/* dv/dspc_top_monitor.sv */
// dspc_top_monitor: port-level assertions on the dsp control block.
// assumes CHAIN_OUT moves only on a group 3 pulse or its clear.
`timescale 1ns/1ns
module dspc_top_monitor
  import dspc_pkg::*;
#(
  parameter int RND_POS = DSPC_RND_POS,
  parameter int SAT_W = DSPC_SAT_W
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [DSPC_ADDR_W-1:0] PADDR,
  input wire logic [DSPC_DATA_W-1:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [DSPC_GROUPS-1:0] BLK_CLK,
  input wire logic [DSPC_GROUPS-1:0] REG_EN,
  input wire logic [DSPC_GROUPS-1:0] ASYNC_CLR_N,
  input wire logic [DSPC_HALVES-1:0] RND2_EN,
  input wire logic [DSPC_HALVES-1:0] SAT2_EN,
  input wire logic [DSPC_ACC_W-1:0] CHAIN_OUT
);
  // ************
  // assertions
  // ************
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);
  wire access_w = PSEL && PENABLE;
  wire bad_w = (PADDR[7:6] != 2'h0) || (PADDR[1:0] != 2'h0);
  wire live_w = ASYNC_CLR_N[3];
  // a change with the clear off on both sides of the edge is a real update
  sequence upd_s;
    $changed(CHAIN_OUT) && live_w && $past(live_w);
  endsequence
  a_ready_high: assert property (PREADY) else $error("pready low");
  a_err_decode: assert property (access_w |-> PSLVERR == bad_w) else $error("pslverr decode wrong");
  a_err_only_access: assert property (PSLVERR |-> access_w) else $error("pslverr outside access");
  a_zero_rdata: assert property (access_w && (PWRITE || bad_w) |-> PRDATA == '0) else $error("prdata not zero");
  a_clr_zero: assert property (!live_w |-> CHAIN_OUT == '0) else $error("cascade not cleared");
  a_chain_en: assert property (upd_s |-> $past(REG_EN[3])) else $error("cascade moved while disabled");
  a_chain_clk: assert property (upd_s |-> $past(BLK_CLK[3], 2) || $past(BLK_CLK[3], 3) ||
    $past(BLK_CLK[3], 4)) else $error("cascade moved without block clock");
  a_sat_range: assert property (upd_s ##0 $past(SAT2_EN[1]) |->
    (CHAIN_OUT[DSPC_ACC_W-1:SAT_W-1] == '0) || (CHAIN_OUT[DSPC_ACC_W-1:SAT_W-1] == '1))
    else $error("cascade outside saturation range");
  a_rnd_low: assert property (upd_s ##0 ($past(RND2_EN[1]) && !$past(SAT2_EN[1])) |->
    CHAIN_OUT[RND_POS-1:0] == '0) else $error("cascade not rounded");
  c_sat_upd: cover property (upd_s ##0 $past(SAT2_EN[1]));
  c_error: cover property (PSLVERR);
  c_clear: cover property (!live_w ##1 live_w);
endmodule
bind dspc_top dspc_top_monitor #(.RND_POS(RND_POS), .SAT_W(SAT_W)) u_mon (
  .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .BLK_CLK(BLK_CLK), .REG_EN(REG_EN),
  .ASYNC_CLR_N(ASYNC_CLR_N), .RND2_EN(RND2_EN), .SAT2_EN(SAT2_EN), .CHAIN_OUT(CHAIN_OUT));

/* dv/test_dsp_block_dynamic_controls.sv */
// test_dsp_block_dynamic_controls: self-checking bench for dspc_top.
// assumes zero-wait apb and the fabric model pacing the block clocks.
`timescale 1ns/1ns
module test_dsp_block_dynamic_controls
  import dspc_pkg::*;
();
  // ************
  // signals
  // ************
  logic clk = 1'b0;
  logic arst_n, psel, penable, pwrite, pready, pslverr, go, en, busy, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] blk_clk, reg_en, clr_n;
  logic [1:0] grp, sa, sb, r1, r2, s1, s2, sl, zc, zl, rot, sr, mo1, mo2, mode;
  logic [43:0] chain_in, chain_out;
  logic [31:0] opa[2], opb[2], ma[2], mb[2], msh[2];
  longint mp[2], mac[2], mco[2], nx[2];
  int error_cnt = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  dspc_top dut (.CLK_SYS(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BLK_CLK(blk_clk), .REG_EN(reg_en), .ASYNC_CLR_N(clr_n), .SIGN_A(sa), .SIGN_B(sb),
    .RND1_EN(r1), .RND2_EN(r2), .SAT1_EN(s1), .SAT2_EN(s2), .ACC_SLOAD(sl), .ZERO_CHAIN(zc),
    .ZERO_LOOP(zl), .ROTATE(rot), .SHIFT_RIGHT(sr), .CHAIN_IN(chain_in), .CHAIN_OUT(chain_out));
  dspc_fabric_model #(.HALF_T(4)) u_fab (.clk(clk), .rst_n(arst_n), .go(go), .grp(grp), .en(en),
    .blk_clk(blk_clk), .reg_en(reg_en), .busy(busy));
  // ************
  // reference model
  // ************
  function automatic longint sx(longint v);
    return (v <<< (64 - DSPC_ACC_W)) >>> (64 - DSPC_ACC_W);
  endfunction
  // saturation acts on the rounded value
  function automatic longint rs(longint x, logic r, logic s, output logic o);
    longint lim;
    lim = 64'sh1 <<< (DSPC_SAT_W - 1);
    o = 1'b0;
    if (r)
      x = (x + (64'sh1 <<< (DSPC_RND_POS - 1))) & ~((64'sh1 <<< DSPC_RND_POS) - 1);
    if (s && (x >= lim || x < -lim))
      o = 1'b1;
    if (s && x >= lim)
      x = lim - 1;
    if (s && x < -lim)
      x = -lim;
    return sx(x);
  endfunction
  function automatic logic [31:0] shf(logic [31:0] v, logic [4:0] n, logic sg, logic ro, logic rt);
    logic [63:0] d;
    d = {v, v} << n;
    if (ro && rt)
      return 32'({v, v} >> n);
    if (ro)
      return d[63:32];
    if (rt && sg)
      return 32'($signed(v) >>> n);
    if (rt)
      return v >> n;
    return v << n;
  endfunction
  // ************
  // tasks
  // ************
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [43:0] seen, input logic [43:0] exp, input string nm);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string nm);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, '0, q, e);
    chk(q, x, nm);
  endtask
  task automatic check_half(input int h);
    logic [7:0] b;
    b = 8'(h * 32);
    rdc(b + 8'h0C, mco[h][31:0], "res_lo");
    rdc(b + 8'h10, 32'(mco[h][43:32]), "res_hi");
    rdc(b + 8'h14, msh[h], "shift");
    rdc(b + 8'h18, mac[h][31:0], "acc_lo");
    rdc(b + 8'h1C, 32'({mo2[h], mo1[h]}), "status");
  endtask
  task automatic step(input int k, input logic e);
    int t;
    longint p;
    @(posedge clk);
    go <= 1'b1;
    grp <= 2'(k);
    en <= e;
    @(posedge clk);
    go <= 1'b0;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (busy !== 1'b0 && t < 40);
    if (busy !== 1'b0) begin
      error_cnt++;
      tally_and_finish();
    end
    for (int h = 0; h < 2; h++) begin
      p = (sa[h] ? longint'($signed(ma[h][17:0])) : longint'(ma[h][17:0])) *
        (sb[h] ? longint'($signed(mb[h][17:0])) : longint'(mb[h][17:0]));
      nx[h] = sx((zc[h] ? 0 : (h == 1 ? mco[0] : sx(longint'(chain_in)))) + (zl[h] ? 0 : mco[h]) + mac[h]);
      if (e && k == 0)
        {ma[h], mb[h]} = {opa[h], opb[h]};
      if (e && k == 1)
        mp[h] = rs(p, r1[h], s1[h], mo1[h]);
      if (e && k == 2 && mode[h])
        msh[h] = shf(ma[h], mb[h][4:0], sa[h], rot[h], sr[h]);
      if (e && k == 2 && !mode[h])
        mac[h] = sx((sl[h] ? 0 : mac[h]) + mp[h]);
      if (e && k == 3)
        nx[h] = rs(nx[h], r2[h], s2[h], mo2[h]);
    end
    if (e && k == 3)
      mco = nx;
  endtask
  task automatic clr(input int k);
    @(posedge clk);
    clr_n[k] <= 1'b0;
    @(posedge clk);
    clr_n[k] <= 1'b1;
    for (int h = 0; h < 2; h++) begin
      if (k == 0)
        {ma[h], mb[h]} = '0;
      if (k == 1)
        {mp[h], mo1[h]} = '0;
      if (k == 2)
        {mac[h], msh[h]} = '0;
      if (k == 3)
        {mco[h], mo2[h]} = '0;
    end
    if (k == 3)
      chk(chain_out, '0, "cleared cascade");
  endtask
  // ************
  // main sequence
  // ************
  initial begin
    {arst_n, psel, penable, pwrite, go, en, paddr, pwdata, grp, chain_in} = '0;
    clr_n = '1;
    {sa, sb, r1, r2, s1, s2, sl, zc, zl, rot, sr, mo1, mo2, mode} = '0;
    for (int h = 0; h < 2; h++)
      {opa[h], opb[h], ma[h], mb[h], msh[h], mp[h], mac[h], mco[h]} = '0;
    void'($urandom(81952));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b1, 8'h0C, 32'hFFFFFFFF, rd, er);
    apb(1'b0, 8'h40, '0, rd, er);
    chk(er, 1'b1, "unmapped error");
    chk(rd, '0, "unmapped data");
    apb(1'b1, 8'h26, 32'h1, rd, er);
    chk(er, 1'b1, "misaligned error");
    check_half(0);
    check_half(1);
    // sign pair walks all four codes; second half of the run is shift mode
    for (int i = 0; i < 48; i++) begin
      sa <= {2{i[1]}};
      sb <= {2{i[0]}};
      {r1, r2, s1, s2, sl, zc, zl, rot, sr} <= 18'($urandom);
      chain_in <= 44'({$urandom, $urandom});
      if (i == 24) begin
        mode = 2'h3;
        apb(1'b1, 8'h08, 32'h1, rd, er);
        apb(1'b1, 8'h28, 32'h1, rd, er);
      end
      for (int h = 0; h < 2; h++) begin
        opa[h] = $urandom;
        opb[h] = $urandom;
        apb(1'b1, 8'(h * 32), opa[h], rd, er);
        apb(1'b1, 8'(h * 32 + 4), opb[h], rd, er);
      end
      for (int k = 0; k < 4; k++)
        step(k, $urandom_range(0, 5) != 0);
      if ($urandom_range(0, 5) == 0)
        clr($urandom_range(0, 3));
      check_half(0);
      check_half(1);
      chk(chain_out, 44'(mco[1]), "chain_out");
    end
    tally_and_finish();
  end
endmodule

/* verilog/dspc_pkg.sv */
// dspc_pkg: widths, register group indices, register map and types
// shared by the dsp control block and its round/saturate stage.
// assumes a SystemVerilog compiler; holds definitions only.
package dspc_pkg;

  // ************************************************************
  // datapath sizes
  // ************************************************************
  localparam int DSPC_HALVES = 2;
  localparam int DSPC_GROUPS = 4;
  localparam int DSPC_OP_W = 18;
  localparam int DSPC_EXT_W = 19;
  localparam int DSPC_PRD_W = 38;
  localparam int DSPC_ACC_W = 44;
  localparam int DSPC_SH_W = 32;
  localparam int DSPC_AMT_W = 5;
  localparam int DSPC_RND_POS = 16;
  localparam int DSPC_SAT_W = 36;
  localparam int DSPC_SYNC_W = 3;

  // ************************************************************
  // register groups: each has its own clock, enable and clear
  // ************************************************************
  localparam int DSPC_GRP_IN = 0;
  localparam int DSPC_GRP_PIPE = 1;
  localparam int DSPC_GRP_ACC = 2;
  localparam int DSPC_GRP_CHAIN = 3;

  // ************************************************************
  // apb register map, one block of words per half
  // ************************************************************
  localparam int DSPC_ADDR_W = 8;
  localparam int DSPC_DATA_W = 32;
  localparam int DSPC_HALF_BIT = 5;
  localparam int DSPC_OFS_W = 5;
  localparam logic [DSPC_OFS_W-1:0] DSPC_OFS_OPA = 5'h00;
  localparam logic [DSPC_OFS_W-1:0] DSPC_OFS_OPB = 5'h04;
  localparam logic [DSPC_OFS_W-1:0] DSPC_OFS_MODE = 5'h08;
  localparam logic [DSPC_OFS_W-1:0] DSPC_OFS_RES_LO = 5'h0C;
  localparam logic [DSPC_OFS_W-1:0] DSPC_OFS_RES_HI = 5'h10;
  localparam logic [DSPC_OFS_W-1:0] DSPC_OFS_SHIFT = 5'h14;
  localparam logic [DSPC_OFS_W-1:0] DSPC_OFS_ACC_LO = 5'h18;
  localparam logic [DSPC_OFS_W-1:0] DSPC_OFS_STATUS = 5'h1C;
  localparam logic [DSPC_DATA_W-1:0] DSPC_WORD_RST = 32'h00000000;
  localparam int DSPC_ST_OVF1 = 0;
  localparam int DSPC_ST_OVF2 = 1;

  typedef enum logic {DSPC_MODE_MAC, DSPC_MODE_SHIFT} dspc_mode_t;

endpackage

/* verilog/dspc_rnd_sat.sv */
// dspc_rnd_sat: one round/saturate stage, purely combinational.
// assumes a two's complement input; rounding and saturation
// positions are fixed at build time by parameters.
`timescale 1ns/1ns
module dspc_rnd_sat
  import dspc_pkg::*;
#(
  parameter int W = DSPC_ACC_W,
  parameter int RND_POS = DSPC_RND_POS,
  parameter int SAT_W = DSPC_SAT_W,
  parameter bit SAT_SYM = 1'b0
) (
  input wire logic [W-1:0] din,
  input wire logic rnd_en,
  input wire logic sat_en,
  output logic [W-1:0] dout,
  output logic ovf
);

  // ************************************************************
  // constants
  // ************************************************************
  localparam logic [W:0] HALF = (W+1)'(1) << (RND_POS - 1);
  localparam logic [W:0] KEEP = ~(W+1)'(0) << RND_POS;
  localparam logic [W-1:0] MAX = W'({(SAT_W-1){1'b1}});
  localparam logic [W-1:0] MIN = SAT_SYM ? W'(~MAX + W'(1)) : ~MAX;

  // ************************************************************
  // round then saturate
  // ************************************************************
  // one guard bit so rounding up the largest value cannot wrap
  wire logic [W:0] ext = {din[W-1], din};
  wire logic [W:0] rnd_sum = (ext + HALF) & KEEP;
  wire logic [W:0] rnd = rnd_en ? rnd_sum : ext;
  wire logic pos_ovf = $signed(rnd) > $signed({1'b0, MAX});
  wire logic neg_ovf = $signed(rnd) < $signed({MIN[W-1], MIN});

  // saturation looks at the rounded value only
  assign ovf = sat_en & (pos_ovf | neg_ovf);
  assign dout = !sat_en ? rnd[W-1:0] : pos_ovf ? MAX : neg_ovf ? MIN : rnd[W-1:0];

endmodule

/* verilog/dspc_top.sv */
// dspc_top: dynamic control side of a two-half multiply/accumulate
// block with shift mode, operands and results reached over apb.
// assumes the dynamic controls and register enables come from logic
// on CLK_SYS; block clock pins are asynchronous and are sampled.
//
// Notes on behaviour
// - per-half sign bits qualify the 18-bit multiplicand and multiplier operands.
// - sign pair 11 signed*signed, 10 signed*unsigned, 01 unsigned*signed, 00 unsigned.
// - first-stage round enable rounds the product, otherwise passes it unrounded.
// - second-stage round enable rounds the cascade result, otherwise unrounded.
// - first-stage saturate enable saturates the product, otherwise no saturation.
// - second-stage saturate enable saturates the cascade result, otherwise none.
// - with both enabled, saturation acts on the already rounded value.
// - reload low feeds back the output register, reload high forces zero.
// - per-half control replaces the incoming cascade value with zero.
// - per-half control replaces the loopback value with zero.
// - rotate high selects 32-bit rotation in shift mode.
// - right-shift select high shifts right instead of left.
// - four block clocks, enables and clears shared by both halves; other dynamic controls per half.
// - four enables gate updates of the registers on their clock.
// - four active-low clears reset their registers without any clock.
// - reload loads the product alone, or its negation with ACC_SUB set, else accumulates with feedback.
// - rotate, right select and sign bits pick the 32-bit shift kind.
`timescale 1ns/1ns
module dspc_top
  import dspc_pkg::*;
#(
  parameter int RND_POS = DSPC_RND_POS,
  parameter int SAT_W = DSPC_SAT_W,
  parameter bit SAT_SYM = 1'b0,
  parameter bit ACC_SUB = 1'b0
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [DSPC_ADDR_W-1:0] PADDR,
  input wire logic [DSPC_DATA_W-1:0] PWDATA,
  output logic [DSPC_DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [DSPC_GROUPS-1:0] BLK_CLK,
  input wire logic [DSPC_GROUPS-1:0] REG_EN,
  input wire logic [DSPC_GROUPS-1:0] ASYNC_CLR_N,
  input wire logic [DSPC_HALVES-1:0] SIGN_A,
  input wire logic [DSPC_HALVES-1:0] SIGN_B,
  input wire logic [DSPC_HALVES-1:0] RND1_EN,
  input wire logic [DSPC_HALVES-1:0] RND2_EN,
  input wire logic [DSPC_HALVES-1:0] SAT1_EN,
  input wire logic [DSPC_HALVES-1:0] SAT2_EN,
  input wire logic [DSPC_HALVES-1:0] ACC_SLOAD,
  input wire logic [DSPC_HALVES-1:0] ZERO_CHAIN,
  input wire logic [DSPC_HALVES-1:0] ZERO_LOOP,
  input wire logic [DSPC_HALVES-1:0] ROTATE,
  input wire logic [DSPC_HALVES-1:0] SHIFT_RIGHT,
  input wire logic [DSPC_ACC_W-1:0] CHAIN_IN,
  output logic [DSPC_ACC_W-1:0] CHAIN_OUT
);

  // ************************************************************
  // functions
  // ************************************************************
  // sign bit set: operand msb extends, clear: zero extends
  function automatic logic [DSPC_EXT_W-1:0] op_ext(input logic [DSPC_OP_W-1:0] v, input logic sgn);
    op_ext = {sgn & v[DSPC_OP_W-1], v};
  endfunction

  // write strobe for one word of one half
  function automatic logic wr_hit(input logic sel, input logic [DSPC_OFS_W-1:0] ofs_in, code);
    wr_hit = sel & (ofs_in == code);
  endfunction

  function automatic logic [DSPC_SH_W-1:0] shift_fn(
    input logic [DSPC_SH_W-1:0] v,
    input logic [DSPC_AMT_W-1:0] n,
    input logic sgn,
    input logic rot,
    input logic rgt
  );
    logic [2*DSPC_SH_W-1:0] dbl;
    dbl = {v, v};
    if (rot && rgt) begin
      shift_fn = DSPC_SH_W'(dbl >> n);
    end else if (rot) begin
      shift_fn = dbl[2*DSPC_SH_W-1:DSPC_SH_W] << n | v >> (DSPC_SH_W - 1 - n) >> 1;
    end else if (rgt && sgn) begin
      shift_fn = DSPC_SH_W'($signed(v) >>> n);
    end else if (rgt) begin
      shift_fn = v >> n;
    end else begin
      shift_fn = v << n;
    end
  endfunction

  // ************************************************************
  // block clock sampling and register group controls
  // ************************************************************
  // a block clock pin is sampled, so its rate must stay well below
  // half of CLK_SYS; each rising edge becomes a one-cycle enable
  logic [DSPC_GROUPS-1:0] clk_s1_reg;
  logic [DSPC_GROUPS-1:0] clk_s2_reg;
  logic [DSPC_GROUPS-1:0] clk_s3_reg;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      clk_s1_reg <= '0;
      clk_s2_reg <= '0;
      clk_s3_reg <= '0;
    end else begin
      clk_s1_reg <= BLK_CLK;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
    end
  end

  wire logic [DSPC_GROUPS-1:0] clk_rise = clk_s2_reg & ~clk_s3_reg;
  wire logic [DSPC_GROUPS-1:0] grp_en = clk_rise & REG_EN;
  // clear pins assert their group at once; release is retimed
  // to CLK_SYS so no group leaves reset on a metastable edge
  wire logic [DSPC_GROUPS-1:0] clr_in_n = {DSPC_GROUPS{ARST_N}} & ASYNC_CLR_N;
  wire logic [DSPC_GROUPS-1:0] grp_rst_n;

  for (genvar g = 0; g < DSPC_GROUPS; g++) begin : g_clr
    logic rel_s1_reg;
    logic rel_s2_reg;
    always_ff @(posedge CLK_SYS or negedge clr_in_n[g]) begin
      if (!clr_in_n[g]) begin
        rel_s1_reg <= 1'b0;
        rel_s2_reg <= 1'b0;
      end else begin
        rel_s1_reg <= 1'b1;
        rel_s2_reg <= rel_s1_reg;
      end
    end
    assign grp_rst_n[g] = rel_s2_reg;
  end

  // ************************************************************
  // apb decode
  // ************************************************************
  wire logic apb_setup = PSEL & ~PENABLE;
  wire logic apb_wr = PSEL & PENABLE & PWRITE;
  wire logic [DSPC_OFS_W-1:0] ofs = PADDR[DSPC_OFS_W-1:0];
  wire logic half_sel = PADDR[DSPC_HALF_BIT];
  wire logic page_ok = PADDR[DSPC_ADDR_W-1:DSPC_HALF_BIT+1] == '0;
  wire logic addr_ok = page_ok & (ofs[1:0] == 2'b00);
  wire logic [DSPC_HALVES-1:0] wr_opa;
  wire logic [DSPC_HALVES-1:0] wr_opb;
  wire logic [DSPC_HALVES-1:0] wr_mode;
  logic [DSPC_DATA_W-1:0] rd_half [DSPC_HALVES];
  logic [DSPC_ACC_W-1:0] chain_src [DSPC_HALVES+1];

  assign chain_src[0] = CHAIN_IN;

  // ************************************************************
  // one datapath per half
  // ************************************************************
  for (genvar h = 0; h < DSPC_HALVES; h++) begin : g_half
    logic [DSPC_DATA_W-1:0] opa_reg;
    logic [DSPC_DATA_W-1:0] opb_reg;
    dspc_mode_t mode_reg;
    logic [DSPC_SH_W-1:0] a_reg;
    logic [DSPC_SH_W-1:0] b_reg;
    logic [DSPC_ACC_W-1:0] pipe_reg;
    logic ovf1_reg;
    logic [DSPC_ACC_W-1:0] acc_reg;
    logic [DSPC_SH_W-1:0] sh_reg;
    logic [DSPC_ACC_W-1:0] co_reg;
    logic ovf2_reg;
    logic [DSPC_ACC_W-1:0] acc_next;
    logic [DSPC_ACC_W-1:0] s1_val;
    logic [DSPC_ACC_W-1:0] s2_val;
    logic s1_ovf;
    logic s2_ovf;
    logic hit;

    // upper pages and misaligned words answer with an error instead
    assign hit = addr_ok & (half_sel == 1'(h));
    assign wr_opa[h] = wr_hit(apb_wr & hit, ofs, DSPC_OFS_OPA);
    assign wr_opb[h] = wr_hit(apb_wr & hit, ofs, DSPC_OFS_OPB);
    assign wr_mode[h] = wr_hit(apb_wr & hit, ofs, DSPC_OFS_MODE);

    // mode follows ARST_N only; the group clears leave it alone
    // software-written operands and mode
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
        opa_reg <= DSPC_WORD_RST;
        opb_reg <= DSPC_WORD_RST;
        mode_reg <= DSPC_MODE_MAC;
      end else begin
        if (wr_opa[h]) begin
          opa_reg <= PWDATA;
        end
        if (wr_opb[h]) begin
          opb_reg <= PWDATA;
        end
        if (wr_mode[h]) begin
          mode_reg <= dspc_mode_t'(PWDATA[0]);
        end
      end
    end

    // input registers
    always_ff @(posedge CLK_SYS or negedge grp_rst_n[DSPC_GRP_IN]) begin
      if (!grp_rst_n[DSPC_GRP_IN]) begin
        a_reg <= '0;
        b_reg <= '0;
      end else if (grp_en[DSPC_GRP_IN]) begin
        a_reg <= opa_reg;
        b_reg <= opb_reg;
      end
    end

    // product of the sign-qualified 18-bit operands, widened to 44 bits
    wire logic signed [DSPC_PRD_W-1:0] prod =
      $signed(op_ext(a_reg[DSPC_OP_W-1:0], SIGN_A[h])) * $signed(op_ext(b_reg[DSPC_OP_W-1:0], SIGN_B[h]));
    wire logic [DSPC_ACC_W-1:0] prod_w = DSPC_ACC_W'(prod);

    dspc_rnd_sat #(
      .W(DSPC_ACC_W),
      .RND_POS(RND_POS),
      .SAT_W(SAT_W),
      .SAT_SYM(SAT_SYM)
    ) u_stage1 (
      .din(prod_w),
      .rnd_en(RND1_EN[h]),
      .sat_en(SAT1_EN[h]),
      .dout(s1_val),
      .ovf(s1_ovf)
    );

    // pipeline registers
    always_ff @(posedge CLK_SYS or negedge grp_rst_n[DSPC_GRP_PIPE]) begin
      if (!grp_rst_n[DSPC_GRP_PIPE]) begin
        pipe_reg <= '0;
        ovf1_reg <= 1'b0;
      end else if (grp_en[DSPC_GRP_PIPE]) begin
        pipe_reg <= s1_val;
        ovf1_reg <= s1_ovf;
      end
    end

    // the sum wraps at 44 bits; only the round/saturate stages clamp
    // reload zeroes the feedback, so the accumulator takes the product alone, negated when ACC_SUB is set
    wire logic [DSPC_ACC_W-1:0] acc_fb = ACC_SLOAD[h] ? '0 : acc_reg;
    assign acc_next = ACC_SUB ? acc_fb - pipe_reg : acc_fb + pipe_reg;

    // accumulator and shift output registers; mode picks which updates
    always_ff @(posedge CLK_SYS or negedge grp_rst_n[DSPC_GRP_ACC]) begin
      if (!grp_rst_n[DSPC_GRP_ACC]) begin
        acc_reg <= '0;
        sh_reg <= '0;
      end else if (grp_en[DSPC_GRP_ACC]) begin
        if (mode_reg == DSPC_MODE_MAC) begin
          acc_reg <= acc_next;
        end else begin
          // shift mode holds the accumulator so a multiply run can resume
          sh_reg <= shift_fn(a_reg, b_reg[DSPC_AMT_W-1:0], SIGN_A[h], ROTATE[h], SHIFT_RIGHT[h]);
        end
      end
    end

    // second stage: cascade in plus own loopback plus accumulator
    wire logic [DSPC_ACC_W-1:0] chain_val = ZERO_CHAIN[h] ? '0 : chain_src[h];
    wire logic [DSPC_ACC_W-1:0] loop_val = ZERO_LOOP[h] ? '0 : co_reg;
    wire logic [DSPC_ACC_W-1:0] s2_sum = chain_val + loop_val + acc_reg;

    dspc_rnd_sat #(
      .W(DSPC_ACC_W),
      .RND_POS(RND_POS),
      .SAT_W(SAT_W),
      .SAT_SYM(SAT_SYM)
    ) u_stage2 (
      .din(s2_sum),
      .rnd_en(RND2_EN[h]),
      .sat_en(SAT2_EN[h]),
      .dout(s2_val),
      .ovf(s2_ovf)
    );

    // cascade output registers
    always_ff @(posedge CLK_SYS or negedge grp_rst_n[DSPC_GRP_CHAIN]) begin
      if (!grp_rst_n[DSPC_GRP_CHAIN]) begin
        co_reg <= '0;
        ovf2_reg <= 1'b0;
      end else if (grp_en[DSPC_GRP_CHAIN]) begin
        co_reg <= s2_val;
        ovf2_reg <= s2_ovf;
      end
    end

    assign chain_src[h+1] = co_reg;

    // read view of this half
    always_comb begin
      rd_half[h] = DSPC_WORD_RST;
      case (ofs)
        DSPC_OFS_OPA: rd_half[h] = opa_reg;
        DSPC_OFS_OPB: rd_half[h] = opb_reg;
        DSPC_OFS_MODE: rd_half[h] = DSPC_DATA_W'(mode_reg);
        DSPC_OFS_RES_LO: rd_half[h] = co_reg[DSPC_DATA_W-1:0];
        DSPC_OFS_RES_HI: rd_half[h] = DSPC_DATA_W'(co_reg[DSPC_ACC_W-1:DSPC_DATA_W]);
        DSPC_OFS_SHIFT: rd_half[h] = sh_reg;
        DSPC_OFS_ACC_LO: rd_half[h] = acc_reg[DSPC_DATA_W-1:0];
        DSPC_OFS_STATUS: begin
          rd_half[h][DSPC_ST_OVF1] = ovf1_reg;
          rd_half[h][DSPC_ST_OVF2] = ovf2_reg;
        end
        default: rd_half[h] = DSPC_WORD_RST;
      endcase
    end
  end

  // the last half's cascade register leaves the block
  assign CHAIN_OUT = chain_src[DSPC_HALVES];

  // ************************************************************
  // apb answer
  // ************************************************************
  // read data and error are latched in the setup cycle so they come
  // from flops while the slave still answers with no wait state
  logic [DSPC_DATA_W-1:0] prdata_reg;
  logic pslverr_reg;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata_reg <= DSPC_WORD_RST;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      prdata_reg <= (addr_ok && !PWRITE) ? rd_half[half_sel] : DSPC_WORD_RST;
      pslverr_reg <= ~addr_ok;
    end
  end

  // no wait states: the setup cycle already latched the answer
  assign PREADY = 1'b1;
  assign PRDATA = prdata_reg;
  assign PSLVERR = pslverr_reg & PSEL & PENABLE;

endmodule
